// [enclave_build_pkg.sv]
// Constants, codes and types shared by the enclave build tracker files.
// Assumes one 125 MHz clock and a plain register port with byte addresses.
package enclave_build_pkg;
	localparam logic [7:0] REG_CMD = 8'h00;
	localparam logic [7:0] REG_LADDR = 8'h04;
	localparam logic [7:0] REG_PERM = 8'h08;
	localparam logic [7:0] REG_BASE = 8'h0C;
	localparam logic [7:0] REG_SIZE = 8'h10;
	localparam logic [7:0] REG_ATTR = 8'h14;
	localparam logic [7:0] REG_MISC = 8'h18;
	localparam logic [7:0] REG_SSA = 8'h1C;
	localparam logic [7:0] REG_EXPECT = 8'h20;
	localparam logic [7:0] REG_SIGMASK = 8'h24;
	localparam logic [7:0] REG_ISV = 8'h28;
	localparam logic [7:0] REG_PSEL = 8'h2C;
	localparam logic [7:0] REG_FLAGS_LO = 8'h30;
	localparam logic [7:0] REG_FLAGS_HI = 8'h34;
	localparam logic [7:0] REG_IDENT = 8'h38;
	localparam logic [7:0] REG_SIGNER = 8'h3C;
	localparam int CMD_OP_POS = 0;
	localparam int CMD_SLOT_POS = 8;
	localparam int CMD_PAGE_POS = 16;
	localparam int CMD_REGION_POS = 24;
	localparam int PERM_TYPE_POS = 8;
	localparam int STAT_FAULT_POS = 4;
	localparam logic [2:0] OP_CREATE = 3'h1;
	localparam logic [2:0] OP_ADD = 3'h2;
	localparam logic [2:0] OP_EXTEND = 3'h3;
	localparam logic [2:0] OP_INIT = 3'h4;
	localparam logic [2:0] OP_ENTER = 3'h5;
	localparam logic [7:0] CONTROL_PAGE_TYPE = 8'h00;
	localparam logic [7:0] THREAD_CONTROL_PAGE_TYPE = 8'h01;
	localparam logic [7:0] REGULAR_PAGE_TYPE = 8'h02;
	localparam int FLAG_READ = 0;
	localparam int FLAG_WRITE = 1;
	localparam int FLAG_EXEC = 2;
	localparam int FLAG_PENDING = 3;
	localparam int FLAG_MODIFIED = 4;
	localparam int FLAG_RESTRICTED = 5;
	localparam int FLAG_TYPE_LSB = 8;
	localparam int FLAG_BLOCKED = 63;
	localparam int ATTR_INIT_BIT = 0;
	localparam int PAGE_BYTES = 4096;
	localparam int REGION_BYTES = 256;
	localparam int REGIONS = PAGE_BYTES / REGION_BYTES;
	localparam logic [31:0] LOG_SEED = 32'h6A09E667;
	localparam logic [1:0] HELP_COPY = 2'h0;
	localparam logic [1:0] HELP_MEASURE = 2'h1;
	localparam logic [1:0] HELP_VERIFY = 2'h2;
	localparam logic [3:0] F_NONE = 4'h0;
	localparam logic [3:0] F_BAD_OP = 4'h1;
	localparam logic [3:0] F_SLOT_USED = 4'h2;
	localparam logic [3:0] F_PAGE_BUSY = 4'h3;
	localparam logic [3:0] F_NO_ENCLAVE = 4'h4;
	localparam logic [3:0] F_INITIALIZED = 4'h5;
	localparam logic [3:0] F_BAD_TYPE = 4'h6;
	localparam logic [3:0] F_RANGE = 4'h7;
	localparam logic [3:0] F_NOT_OWNED = 4'h8;
	localparam logic [3:0] F_COPY = 4'h9;
	localparam logic [3:0] F_SIGNATURE = 4'hA;
	localparam logic [3:0] F_MEASURE = 4'hB;
	localparam logic [3:0] F_ATTRIBUTES = 4'hC;
	localparam logic [3:0] F_NOT_INIT = 4'hD;
	typedef enum logic [2:0] {
		S_IDLE = 3'b001,
		S_HELP = 3'b010,
		S_FIN = 3'b100
	} state_t;
endpackage : enclave_build_pkg

// [build_log.sv]
// Order-sensitive running digest of one enclave's build log.
// Assumes the owner never asks for clear and absorb from two sources at once.
`timescale 1ns/1ps
module build_log (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic clear,
	input wire logic absorb,
	input wire logic [63:0] data,
	output logic [31:0] digest_q
);
	import enclave_build_pkg::*;
	logic [31:0] base;
	logic [31:0] digest_d;
	always_comb begin
		base = clear ? LOG_SEED : digest_q;
		digest_d = {base[30:0], base[31]} ^ data[31:0] ^ {data[47:32], data[63:48]};
	end
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			digest_q <= 32'h00000000;
		end else if (clear || absorb) begin
			digest_q <= digest_d;
		end
	end
endmodule : build_log

// [page_flags.sv]
// Packs one page map entry into the 64-bit page status flags word.
// Assumes the caller registers the word before it leaves the block.
`timescale 1ns/1ps
module page_flags (
	input wire logic [2:0] perm,
	input wire logic pending,
	input wire logic modified,
	input wire logic restricted,
	input wire logic blocked,
	input wire logic [7:0] pageType,
	output logic [63:0] flags
);
	import enclave_build_pkg::*;
	always_comb begin
		flags = 64'h0000000000000000;
		flags[FLAG_READ] = perm[0];
		flags[FLAG_WRITE] = perm[1];
		flags[FLAG_EXEC] = perm[2];
		flags[FLAG_PENDING] = pending;
		flags[FLAG_MODIFIED] = modified;
		flags[FLAG_RESTRICTED] = restricted;
		flags[FLAG_TYPE_LSB +: 8] = pageType;
		flags[FLAG_BLOCKED] = blocked;
	end
endmodule : page_flags

// [enclave_build_tracker.sv]
// Command interpreter that builds enclaves and keeps the page map and build logs.
// Assumes an external helper on the same clock copies pages, measures regions
// and verifies signatures plus launch tokens, answering with a one-cycle done.
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module enclave_build_tracker #(
	parameter int NPAGES = 16,
	parameter int NENC = 4,
	parameter int PAGE_W = $clog2(NPAGES),
	parameter int SLOT_W = $clog2(NENC)
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	output logic helpReq,
	output logic [1:0] helpOp,
	output logic [31:0] helpAddr,
	output logic [PAGE_W-1:0] helpPage,
	input wire logic helpDone,
	input wire logic helpOk,
	input wire logic [31:0] helpDigest,
	output logic enterGrant
);
	import enclave_build_pkg::*;

	state_t state_q;
	logic [3:0] fault_q;
	logic [31:0] laddr_q, perm_q, base_q, size_q, attr_q, misc_q, ssa_q;
	logic [31:0] expect_q, sigMask_q, isv_q, psel_q;
	logic [2:0] curOp_q;
	logic [SLOT_W-1:0] curSlot_q;
	logic [PAGE_W-1:0] curPage_q;
	logic [3:0] curRegion_q;
	logic [31:0] curLaddr_q, curPerm_q;
	logic [NPAGES-1:0] mapValid_q, mapBlk_q, mapPend_q, mapMod_q, mapPr_q;
	logic [2:0] mapPerm_q [NPAGES];
	logic [7:0] mapType_q [NPAGES];
	logic [SLOT_W-1:0] mapOwner_q [NPAGES];
	logic [31:0] mapLaddr_q [NPAGES];
	logic [NENC-1:0] encValid_q;
	logic [NENC-1:0] encInit;
	logic [31:0] encBase_q [NENC];
	logic [31:0] encSize_q [NENC];
	logic [31:0] encAttr_q [NENC];
	logic [31:0] encMisc_q [NENC];
	logic [31:0] encSsa_q [NENC];
	logic [PAGE_W-1:0] encPage_q [NENC];
	logic [31:0] encIdent_q [NENC];
	logic [31:0] encSigner_q [NENC];
	logic [31:0] encIsv_q [NENC];
	logic [31:0] logDigest [NENC];
	logic [NENC-1:0] logClear, logAbsorb;
	logic [63:0] logData;
	logic [2:0] wOp;
	logic [SLOT_W-1:0] wSlot;
	logic [PAGE_W-1:0] wPage;
	logic [7:0] wType;
	logic cmdWr;
	logic [3:0] chkFault;
	logic [31:0] regionAddr;
	logic helpEnd;
	logic initPass;
	logic [3:0] initFault;
	logic [63:0] selFlags;

	assign wOp = wdata[CMD_OP_POS +: 3];
	assign wSlot = wdata[CMD_SLOT_POS +: SLOT_W];
	assign wPage = wdata[CMD_PAGE_POS +: PAGE_W];
	assign wType = perm_q[PERM_TYPE_POS +: 8];
	assign cmdWr = wr && (addr == REG_CMD) && (state_q == S_IDLE);
	assign helpEnd = (state_q == S_HELP) && helpDone;
	assign regionAddr = mapLaddr_q[curPage_q] + {20'h00000, curRegion_q, 8'h00};

	genvar g;
	generate
		for (g = 0; g < NENC; g++) begin : gLog
			assign encInit[g] = encAttr_q[g][ATTR_INIT_BIT];
			build_log uLog (
				.clk_sys(clk_sys),
				.srst(srst),
				.clear(logClear[g]),
				.absorb(logAbsorb[g]),
				.data(logData),
				.digest_q(logDigest[g])
			);
		end
	endgenerate

	page_flags uFlags (
		.perm(mapPerm_q[psel_q[PAGE_W-1:0]]),
		.pending(mapPend_q[psel_q[PAGE_W-1:0]]),
		.modified(mapMod_q[psel_q[PAGE_W-1:0]]),
		.restricted(mapPr_q[psel_q[PAGE_W-1:0]]),
		.blocked(mapBlk_q[psel_q[PAGE_W-1:0]]),
		.pageType(mapType_q[psel_q[PAGE_W-1:0]]),
		.flags(selFlags)
	);

	// Checks that a command can start, evaluated in the cycle it is written.
	always_comb begin
		chkFault = F_NONE;
		case (wOp)
			OP_CREATE: begin
				if (encValid_q[wSlot]) chkFault = F_SLOT_USED;
				else if (mapValid_q[wPage]) chkFault = F_PAGE_BUSY;
			end
			OP_ADD: begin
				if (!encValid_q[wSlot]) chkFault = F_NO_ENCLAVE;
				else if (encInit[wSlot]) chkFault = F_INITIALIZED;
				else if (mapValid_q[wPage]) chkFault = F_PAGE_BUSY;
				else if (wType != REGULAR_PAGE_TYPE && wType != THREAD_CONTROL_PAGE_TYPE)
					chkFault = F_BAD_TYPE;
				else if (laddr_q < encBase_q[wSlot] ||
					(laddr_q - encBase_q[wSlot]) >= encSize_q[wSlot])
					chkFault = F_RANGE;
			end
			OP_EXTEND: begin
				if (!encValid_q[wSlot]) chkFault = F_NO_ENCLAVE;
				else if (encInit[wSlot]) chkFault = F_INITIALIZED;
				else if (!mapValid_q[wPage] || mapOwner_q[wPage] != wSlot ||
					mapType_q[wPage] == CONTROL_PAGE_TYPE)
					chkFault = F_NOT_OWNED;
			end
			OP_INIT: begin
				if (!encValid_q[wSlot]) chkFault = F_NO_ENCLAVE;
				else if (encInit[wSlot]) chkFault = F_INITIALIZED;
			end
			OP_ENTER: begin
				if (!encValid_q[wSlot]) chkFault = F_NO_ENCLAVE;
				else if (!encInit[wSlot]) chkFault = F_NOT_INIT;
			end
			default: chkFault = F_BAD_OP;
		endcase
	end

	// Initialize verdict: signature and token first, then measurement, then attributes.
	always_comb begin
		initFault = F_NONE;
		if (!helpOk) initFault = F_SIGNATURE;
		else if (logDigest[curSlot_q] != expect_q) initFault = F_MEASURE;
		else if ((encAttr_q[curSlot_q][15:0] & ~sigMask_q[15:0]) != 16'h0000 ||
			(encMisc_q[curSlot_q][15:0] & ~sigMask_q[31:16]) != 16'h0000)
			initFault = F_ATTRIBUTES;
	end
	assign initPass = helpEnd && (curOp_q == OP_INIT) && (initFault == F_NONE);

	// Build log feed.
	always_comb begin
		logClear = '0;
		logAbsorb = '0;
		logData = 64'h0000000000000000;
		if (cmdWr && wOp == OP_CREATE && chkFault == F_NONE) begin
			logClear[wSlot] = 1'b1;
			logData = {attr_q, misc_q};
		end else if (helpEnd && helpOk && curOp_q == OP_ADD) begin
			logAbsorb[curSlot_q] = 1'b1;
			logData = {curLaddr_q, 8'h00, curPerm_q[PERM_TYPE_POS +: 8], 13'h0000,
				curPerm_q[2:0]};
		end else if (helpEnd && curOp_q == OP_EXTEND) begin
			logAbsorb[curSlot_q] = 1'b1;
			logData = {regionAddr, helpDigest};
		end
	end

	// Helper request, held for the whole wait.
	always_comb begin
		helpReq = (state_q == S_HELP);
		helpPage = curPage_q;
		case (curOp_q)
			OP_ADD: begin
				helpOp = HELP_COPY;
				helpAddr = curLaddr_q;
			end
			OP_EXTEND: begin
				helpOp = HELP_MEASURE;
				helpAddr = regionAddr;
			end
			default: begin
				helpOp = HELP_VERIFY;
				helpAddr = 32'h00000000;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_q <= S_IDLE;
		end else begin
			case (state_q)
				S_IDLE: begin
					if (cmdWr && chkFault == F_NONE &&
						(wOp == OP_ADD || wOp == OP_EXTEND || wOp == OP_INIT))
						state_q <= S_HELP;
				end
				S_HELP: begin
					if (initPass) state_q <= S_FIN;
					else if (helpDone) state_q <= S_IDLE;
				end
				S_FIN: state_q <= S_IDLE;
				default: state_q <= S_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			fault_q <= F_NONE;
			enterGrant <= 1'b0;
			curOp_q <= 3'h0;
			curSlot_q <= '0;
			curPage_q <= '0;
			curRegion_q <= 4'h0;
			curLaddr_q <= 32'h00000000;
			curPerm_q <= 32'h00000000;
		end else begin
			enterGrant <= cmdWr && wOp == OP_ENTER && chkFault == F_NONE;
			if (cmdWr) begin
				fault_q <= chkFault;
				curOp_q <= wOp;
				curSlot_q <= wSlot;
				curPage_q <= wPage;
				curRegion_q <= wdata[CMD_REGION_POS +: 4];
				curLaddr_q <= laddr_q;
				curPerm_q <= perm_q;
			end else if (helpEnd) begin
				if (curOp_q == OP_INIT) fault_q <= initFault;
				else if (!helpOk) fault_q <= F_COPY;
			end
		end
	end

	// Page map entries.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			mapValid_q <= '0;
			mapBlk_q <= '0;
			mapPend_q <= '0;
			mapMod_q <= '0;
			mapPr_q <= '0;
			for (int i = 0; i < NPAGES; i++) begin
				mapPerm_q[i] <= 3'h0;
				mapType_q[i] <= 8'h00;
				mapOwner_q[i] <= '0;
				mapLaddr_q[i] <= 32'h00000000;
			end
		end else if (cmdWr && wOp == OP_CREATE && chkFault == F_NONE) begin
			mapValid_q[wPage] <= 1'b1;
			mapType_q[wPage] <= CONTROL_PAGE_TYPE;
			mapOwner_q[wPage] <= wSlot;
			mapPerm_q[wPage] <= 3'h0;
			mapLaddr_q[wPage] <= 32'h00000000;
		end else if (helpEnd && helpOk && curOp_q == OP_ADD) begin
			mapValid_q[curPage_q] <= 1'b1;
			mapType_q[curPage_q] <= curPerm_q[PERM_TYPE_POS +: 8];
			mapPerm_q[curPage_q] <= curPerm_q[2:0];
			mapLaddr_q[curPage_q] <= curLaddr_q;
			mapOwner_q[curPage_q] <= curSlot_q;
			mapBlk_q[curPage_q] <= 1'b0;
			mapPend_q[curPage_q] <= 1'b0;
			mapMod_q[curPage_q] <= 1'b0;
			mapPr_q[curPage_q] <= 1'b0;
		end
	end

	// Enclave control structures.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			encValid_q <= '0;
			for (int i = 0; i < NENC; i++) begin
				encBase_q[i] <= 32'h00000000;
				encSize_q[i] <= 32'h00000000;
				encAttr_q[i] <= 32'h00000000;
				encMisc_q[i] <= 32'h00000000;
				encSsa_q[i] <= 32'h00000000;
				encPage_q[i] <= '0;
				encIdent_q[i] <= 32'h00000000;
				encSigner_q[i] <= 32'h00000000;
				encIsv_q[i] <= 32'h00000000;
			end
		end else if (cmdWr && wOp == OP_CREATE && chkFault == F_NONE) begin
			encValid_q[wSlot] <= 1'b1;
			encBase_q[wSlot] <= base_q;
			encSize_q[wSlot] <= size_q;
			encAttr_q[wSlot] <= attr_q & ~(32'h00000001 << ATTR_INIT_BIT);
			encMisc_q[wSlot] <= misc_q;
			encSsa_q[wSlot] <= ssa_q;
			encPage_q[wSlot] <= wPage;
		end else if (initPass) begin
			encIdent_q[curSlot_q] <= logDigest[curSlot_q];
			encSigner_q[curSlot_q] <= helpDigest;
			encIsv_q[curSlot_q] <= isv_q;
		end else if (state_q == S_FIN) begin
			encAttr_q[curSlot_q][ATTR_INIT_BIT] <= 1'b1;
		end
	end

	// Software staging registers.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			laddr_q <= 32'h00000000;
			perm_q <= 32'h00000000;
			base_q <= 32'h00000000;
			size_q <= 32'h00000000;
			attr_q <= 32'h00000000;
			misc_q <= 32'h00000000;
			ssa_q <= 32'h00000000;
			expect_q <= 32'h00000000;
			sigMask_q <= 32'h00000000;
			isv_q <= 32'h00000000;
			psel_q <= 32'h00000000;
		end else if (wr) begin
			case (addr)
				REG_LADDR: laddr_q <= wdata;
				REG_PERM: perm_q <= wdata;
				REG_BASE: base_q <= wdata;
				REG_SIZE: size_q <= wdata;
				REG_ATTR: attr_q <= wdata;
				REG_MISC: misc_q <= wdata;
				REG_SSA: ssa_q <= wdata;
				REG_EXPECT: expect_q <= wdata;
				REG_SIGMASK: sigMask_q <= wdata;
				REG_ISV: isv_q <= wdata;
				REG_PSEL: psel_q <= {{(32 - PAGE_W){1'b0}}, wdata[PAGE_W-1:0]};
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rdata <= 32'h00000000;
		end else if (rd) begin
			case (addr)
				REG_CMD: rdata <= {24'h000000, fault_q, 3'h0, state_q != S_IDLE};
				REG_LADDR: rdata <= laddr_q;
				REG_PERM: rdata <= perm_q;
				REG_BASE: rdata <= base_q;
				REG_SIZE: rdata <= size_q;
				REG_ATTR: rdata <= encAttr_q[curSlot_q];
				REG_MISC: rdata <= misc_q;
				REG_SSA: rdata <= encSsa_q[curSlot_q];
				REG_EXPECT: rdata <= expect_q;
				REG_SIGMASK: rdata <= sigMask_q;
				REG_ISV: rdata <= encIsv_q[curSlot_q];
				REG_PSEL: rdata <= psel_q;
				REG_FLAGS_LO: rdata <= selFlags[31:0];
				REG_FLAGS_HI: rdata <= selFlags[63:32];
				REG_IDENT: rdata <= encIdent_q[curSlot_q];
				REG_SIGNER: rdata <= encSigner_q[curSlot_q];
				default: rdata <= 32'h00000000;
			endcase
		end else begin
			rdata <= 32'h00000000;
		end
	end

	logic [2:0] selPerm;
	logic [7:0] selType;
	logic selBlk;
	assign selPerm = mapPerm_q[psel_q[PAGE_W-1:0]];
	assign selType = mapType_q[psel_q[PAGE_W-1:0]];
	assign selBlk = mapBlk_q[psel_q[PAGE_W-1:0]];

	a_flags_perm: assert property (@(posedge clk_sys) disable iff (srst)
		rd && addr == REG_FLAGS_LO |=> rdata[2:0] == $past(selPerm))
		else $error("Flag permission bits differ from map entry.");
	a_flags_type: assert property (@(posedge clk_sys) disable iff (srst)
		rd && addr == REG_FLAGS_LO |=> rdata[15:8] == $past(selType) && rdata[7:6] == 2'h0)
		else $error("Flag type field wrong or reserved bits set.");
	a_flags_hi: assert property (@(posedge clk_sys) disable iff (srst)
		rd && addr == REG_FLAGS_HI |=> rdata[31] == $past(selBlk) && rdata[30:0] == 31'h0)
		else $error("Blocked bit wrong or upper reserved bits set.");
	a_add_inited: assert property (@(posedge clk_sys) disable iff (srst)
		cmdWr && (wOp == OP_ADD || wOp == OP_EXTEND) && encValid_q[wSlot] && encInit[wSlot]
		|=> fault_q == F_INITIALIZED && state_q == S_IDLE)
		else $error("Add or extend accepted after initialize.");
	a_enter_early: assert property (@(posedge clk_sys) disable iff (srst)
		cmdWr && wOp == OP_ENTER && !encInit[wSlot] |=> !enterGrant && fault_q != F_NONE)
		else $error("Enter granted before initialize.");
	a_init_last: assert property (@(posedge clk_sys) disable iff (srst)
		$changed(encInit) |-> $past(state_q) == S_FIN)
		else $error("Initialized bit changed outside final step.");
	a_sig_reject: assert property (@(posedge clk_sys) disable iff (srst)
		helpEnd && curOp_q == OP_INIT && !helpOk |=> fault_q == F_SIGNATURE ##1 !$rose(|encInit))
		else $error("Bad signature did not fail initialize.");
	a_create_slot: assert property (@(posedge clk_sys) disable iff (srst)
		cmdWr && wOp == OP_CREATE && chkFault == F_NONE
		|=> encValid_q[$past(wSlot)] && mapType_q[$past(wPage)] == CONTROL_PAGE_TYPE)
		else $error("Create did not claim slot and control page.");
	a_extend_log: assert property (@(posedge clk_sys) disable iff (srst)
		helpEnd && curOp_q == OP_EXTEND |-> logAbsorb[curSlot_q] && logData[31:0] == helpDigest)
		else $error("Extend result not appended to log.");
	c_create: cover property (@(posedge clk_sys) disable iff (srst)
		cmdWr && wOp == OP_CREATE && chkFault == F_NONE);
	c_extend: cover property (@(posedge clk_sys) disable iff (srst)
		helpEnd && curOp_q == OP_EXTEND);
	c_init: cover property (@(posedge clk_sys) disable iff (srst) state_q == S_FIN);
	c_enter: cover property (@(posedge clk_sys) disable iff (srst) enterGrant);
endmodule : enclave_build_tracker

// [tb.sv]
// Self-checking bench for the enclave build tracker, driving commands and helper answers.
// Assumes the default sizes of 16 pages and 4 enclave slots and a 125 MHz clock.
`timescale 1ns/1ps
module tb;
	import enclave_build_pkg::*;
	typedef struct {logic [63:0] v; string nm;} note_t;
	note_t notes[$];
	note_t n1;
	logic clk_sys = 1'b0;
	logic srst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	logic helpReq;
	logic [1:0] helpOp;
	logic [31:0] helpAddr;
	logic [3:0] helpPage;
	logic helpDone = 1'b0;
	logic helpOk = 1'b0;
	logic [31:0] helpDigest = 32'h0;
	logic enterGrant;
	logic rdSeen = 1'b0;
	logic helpPrev = 1'b0;
	int nMismatch = 0;
	int checked = 0;
	int nGrant = 0;
	int cycles = 0;
	integer seed = 19869;
	logic [2:0] perm;
	logic [31:0] logExp = 32'h0;
	logic [31:0] dig;
	enclave_build_tracker #(.NPAGES(16), .NENC(4)) i_dut (.clk_sys(clk_sys), .srst(srst),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .helpReq(helpReq),
		.helpOp(helpOp), .helpAddr(helpAddr), .helpPage(helpPage), .helpDone(helpDone),
		.helpOk(helpOk), .helpDigest(helpDigest), .enterGrant(enterGrant));
	always #4 clk_sys = ~clk_sys;
	task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		checked++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", nm, e, g);
			nMismatch++;
		end
	endtask : chk
	task testDone;
		$display("checks %0d mismatches %0d", checked, nMismatch);
		if (nMismatch == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : testDone
	// The monitor pairs each read result and each helper request with the oldest note.
	always @(posedge clk_sys) begin
		rdSeen <= rd;
		helpPrev <= helpReq;
		if (enterGrant === 1'b1) nGrant++;
		if (rdSeen || (helpReq === 1'b1 && !helpPrev)) begin
			if (notes.size() == 0) chk("note queue", 64'h1, 64'h0);
			else begin
				n1 = notes.pop_front();
				if (rdSeen) chk(n1.nm, n1.v, {32'h0, rdata});
				else chk(n1.nm, n1.v, {26'h0, helpOp, helpPage, helpAddr});
			end
		end
		cycles++;
		if (cycles == 20000) begin
			nMismatch++;
			testDone();
		end
	end
	task wrReg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask : wrReg
	task rdReg(input logic [7:0] a, input logic [31:0] e, input string nm);
		notes.push_back('{{32'h0, e}, nm});
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
	endtask : rdReg
	task cmd(input logic [2:0] op, input logic [1:0] sl, input logic [3:0] pg, input logic [3:0] rg);
		wrReg(REG_CMD, {4'h0, rg, 4'h0, pg, 6'h0, sl, 5'h0, op});
	endtask : cmd
	task status(input logic [3:0] f);
		rdReg(REG_CMD, {24'h0, f, 4'h0}, "status");
	endtask : status
	task expHelp(input logic [1:0] op, input logic [3:0] pg, input logic [31:0] a);
		notes.push_back('{{26'h0, op, pg, a}, "helper request"});
	endtask : expHelp
	// The helper answers after a chosen delay, then scrambles its data lines.
	task helpAns(input logic ok, input logic [31:0] dig, input int dly);
		int n;
		n = 0;
		#1;
		while (helpReq !== 1'b1 && n < 50) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chk("helper wait", 64'h1, {63'h0, n < 50});
		@(posedge clk_sys);
		repeat (dly) @(posedge clk_sys);
		helpDone <= 1'b1;
		helpOk <= ok;
		helpDigest <= dig;
		@(posedge clk_sys);
		helpDone <= 1'b0;
		helpOk <= ~ok;
		helpDigest <= ~dig;
		repeat (2) @(posedge clk_sys);
	endtask : helpAns
	function automatic logic [31:0] logMix(input logic [31:0] d, input logic [63:0] x);
		logMix = {d[30:0], d[31]} ^ x[31:0] ^ {x[47:32], x[63:48]};
	endfunction : logMix
	task flags(input logic [3:0] pg, input logic [7:0] ty, input logic [2:0] pm);
		wrReg(REG_PSEL, {28'h0, pg});
		rdReg(REG_FLAGS_LO, {16'h0, ty, 5'h0, pm}, "flags low");
		rdReg(REG_FLAGS_HI, 32'h0, "flags high");
	endtask : flags
	task addPage(input logic [3:0] pg, input logic [31:0] la, input logic [7:0] ty, input logic ok);
		perm = $random(seed);
		wrReg(REG_LADDR, la);
		wrReg(REG_PERM, {16'h0, ty, 5'h0, perm});
		expHelp(HELP_COPY, pg, la);
		cmd(OP_ADD, 2'h0, pg, 4'h0);
		helpAns(ok, 32'h0, pg);
		if (ok) logExp = logMix(logExp, {la, 8'h00, ty, 13'h0, perm});
	endtask : addPage
	initial begin
		repeat (10) @(posedge clk_sys);
		srst <= 1'b0;
		status(F_NONE);
		rdReg(8'hFC, 32'h0, "unmapped read");
		flags(4'h3, 8'h00, 3'h0);
		wrReg(REG_BASE, 32'h0001_0000);
		wrReg(REG_SIZE, 32'h0001_0000);
		wrReg(REG_ATTR, 32'h0000_0010);
		wrReg(REG_MISC, 32'h0000_0001);
		wrReg(REG_SSA, 32'h0000_0003);
		cmd(OP_CREATE, 2'h0, 4'h0, 4'h0);
		logExp = logMix(LOG_SEED, {32'h0000_0010, 32'h0000_0001});
		status(F_NONE);
		rdReg(REG_SSA, 32'h3, "save frame size");
		cmd(OP_CREATE, 2'h0, 4'h5, 4'h0);
		status(F_SLOT_USED);
		cmd(OP_CREATE, 2'h1, 4'h0, 4'h0);
		status(F_PAGE_BUSY);
		addPage(4'h1, 32'h0001_0000, REGULAR_PAGE_TYPE, 1'b1);
		status(F_NONE);
		flags(4'h1, REGULAR_PAGE_TYPE, perm);
		perm = $random(seed);
		wrReg(REG_LADDR, 32'h0001_1000);
		wrReg(REG_PERM, {16'h0, THREAD_CONTROL_PAGE_TYPE, 5'h0, perm});
		expHelp(HELP_COPY, 4'h2, 32'h0001_1000);
		cmd(OP_ADD, 2'h0, 4'h2, 4'h0);
		cmd(OP_CREATE, 2'h2, 4'h9, 4'h0);
		helpAns(1'b1, 32'h0, 0);
		logExp = logMix(logExp, {32'h0001_1000, 8'h00, THREAD_CONTROL_PAGE_TYPE, 13'h0, perm});
		status(F_NONE);
		flags(4'h2, THREAD_CONTROL_PAGE_TYPE, perm);
		flags(4'h9, 8'h00, 3'h0);
		wrReg(REG_LADDR, 32'h0003_0000);
		cmd(OP_ADD, 2'h0, 4'h4, 4'h0);
		status(F_RANGE);
		wrReg(REG_LADDR, 32'h0001_2000);
		wrReg(REG_PERM, 32'h0000_0007);
		cmd(OP_ADD, 2'h0, 4'h4, 4'h0);
		status(F_BAD_TYPE);
		wrReg(REG_PERM, 32'h0000_0207);
		cmd(OP_ADD, 2'h0, 4'h1, 4'h0);
		status(F_PAGE_BUSY);
		cmd(OP_ADD, 2'h3, 4'h4, 4'h0);
		status(F_NO_ENCLAVE);
		addPage(4'h4, 32'h0001_2000, REGULAR_PAGE_TYPE, 1'b0);
		status(F_COPY);
		flags(4'h4, 8'h00, 3'h0);
		for (int r = 0; r < 16; r++) begin
			dig = $random(seed);
			expHelp(HELP_MEASURE, 4'h1, 32'h0001_0000 + r * 256);
			cmd(OP_EXTEND, 2'h0, 4'h1, r[3:0]);
			helpAns(1'b1, dig, r % 3);
			status(F_NONE);
			logExp = logMix(logExp, {32'h0001_0000 + r * 256, dig});
		end
		cmd(OP_EXTEND, 2'h0, 4'h0, 4'h0);
		status(F_NOT_OWNED);
		cmd(OP_ENTER, 2'h0, 4'h0, 4'h0);
		status(F_NOT_INIT);
		wrReg(REG_SIGMASK, 32'hFFFF_FFFF);
		wrReg(REG_EXPECT, 32'h0);
		expHelp(HELP_VERIFY, 4'h0, 32'h0);
		cmd(OP_INIT, 2'h0, 4'h0, 4'h0);
		helpAns(1'b0, 32'h5A5A_0001, 1);
		status(F_SIGNATURE);
		wrReg(REG_SIGMASK, 32'h0);
		expHelp(HELP_VERIFY, 4'h0, 32'h0);
		cmd(OP_INIT, 2'h0, 4'h0, 4'h0);
		helpAns(1'b1, 32'h5A5A_0001, 0);
		status(F_MEASURE);
		rdReg(REG_ATTR, 32'h0000_0010, "attributes");
		cmd(OP_ENTER, 2'h0, 4'h0, 4'h0);
		status(F_NOT_INIT);
		wrReg(REG_EXPECT, logExp);
		wrReg(REG_ISV, 32'h0003_0007);
		expHelp(HELP_VERIFY, 4'h0, 32'h0);
		cmd(OP_INIT, 2'h0, 4'h0, 4'h0);
		helpAns(1'b1, 32'h5A5A_0001, 2);
		status(F_ATTRIBUTES);
		wrReg(REG_SIGMASK, 32'h0001_0010);
		expHelp(HELP_VERIFY, 4'h0, 32'h0);
		cmd(OP_INIT, 2'h0, 4'h0, 4'h0);
		helpAns(1'b1, 32'h5A5A_0002, 0);
		status(F_NONE);
		rdReg(REG_ATTR, 32'h0000_0011, "initialized attributes");
		rdReg(REG_IDENT, logExp, "identity");
		rdReg(REG_SIGNER, 32'h5A5A_0002, "signer hash");
		rdReg(REG_ISV, 32'h0003_0007, "product and version");
		cmd(OP_ENTER, 2'h0, 4'h0, 4'h0);
		status(F_NONE);
		cmd(OP_EXTEND, 2'h0, 4'h1, 4'h0);
		status(F_INITIALIZED);
		cmd(OP_ADD, 2'h0, 4'h5, 4'h0);
		status(F_INITIALIZED);
		cmd(3'h7, 2'h0, 4'h0, 4'h0);
		status(F_BAD_OP);
		repeat (3) @(posedge clk_sys);
		chk("enter grants", 64'h1, nGrant);
		chk("notes left", 64'h0, notes.size());
		testDone();
	end
endmodule : tb
